// ===== include/ric_pkg.sv
// Package of constants and types for the radio interrupt controller.
package ric_pkg;
	localparam int ADDR_W = 11;
	localparam int DATA_W = 8;
	localparam logic [10:0] PIN1_ENABLE_LOW_ADDR = 11'h3c7;
	localparam logic [10:0] PIN1_ENABLE_HIGH_ADDR = 11'h3c8;
	localparam logic [10:0] PIN2_ENABLE_LOW_ADDR = 11'h3c9;
	localparam logic [10:0] PIN2_ENABLE_HIGH_ADDR = 11'h3ca;
	localparam logic [10:0] EVENT_SOURCE_LOW_ADDR = 11'h3cb;
	localparam logic [10:0] EVENT_SOURCE_HIGH_ADDR = 11'h3cc;
	// Low source register bit positions.
	localparam int LO_CHIP_ACCESSIBLE = 1;
	localparam int LO_TIMER_EXPIRY = 2;
	localparam int LO_CONTROLLER_IDLE = 3;
	localparam int LO_POWER_ON_RESET = 4;
	localparam int LO_BATTERY_ALERT = 5;
	// High source register bit positions.
	localparam int HI_ASSESS_DONE = 0;
	localparam int HI_DELIM_DETECTED = 1;
	localparam int HI_DELIM_SENT = 2;
	localparam int HI_PACKET_RECEIVED = 3;
	localparam int HI_PACKET_SENT = 4;
	// Implemented bits of each source register; the rest are reserved.
	localparam logic [7:0] LO_IMPL_MASK = 8'h3e;
	localparam logic [7:0] HI_IMPL_MASK = 8'h1f;
	// Enable values after power-on or wake: only the chip-accessible enable.
	localparam logic [7:0] EN_LOW_RESET = 8'h02;
	localparam logic [7:0] EN_HIGH_RESET = 8'h00;
	// Source value latched at power-up, except the chip-accessible bit, which ric_top sets on its own.
	localparam logic [7:0] SRC_LOW_POWERUP = 8'h1c;
	localparam logic [7:0] SRC_HIGH_RESET = 8'h00;

	// Raw event inputs from the radio's units, already on the device clock.
	typedef struct packed {
		logic packet_mode;
		logic receive_state;
		logic packet_sent;
		logic packet_received;
		logic frame_check_ok;
		logic delim_sent;
		logic delim_detected;
		logic assess_done;
		logic battery_monitor_on;
		logic battery_low;
		logic controller_idle_flag;
		logic timer_zero;
		logic serial_ready_flag;
	} ric_events_t;

	// One register access from the serial control port.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [10:0] addr;
		logic [7:0] wdata;
	} ric_access_t;
endpackage

// ===== design/ric_edge.sv
// Rising-edge detector used for the status-flag derived events.
`timescale 1ns/100ps
module ric_edge (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Level in, pulse out
	input wire logic level,
	output logic rise
);
	logic level_r;
	logic level_nxt;

	always_comb begin
		level_nxt = level;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			level_r <= 1'b0;
		end else begin
			level_r <= level_nxt;
		end
	end

	assign rise = level & ~level_r;
endmodule

// ===== design/ric_pin.sv
// Interrupt pin driver with enable masking, stream override and sleep tristate.
`timescale 1ns/100ps
module ric_pin (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Sources and enables
	input wire logic [15:0] sources,
	input wire logic [15:0] enables,
	// Override and sleep
	input wire logic override_en,
	input wire logic override_val,
	input wire logic sleep,
	// Pin and request
	output logic pin_o,
	output logic pin_oe_n,
	output logic request
);
	logic pin_r;
	logic pin_nxt;
	logic oe_n_r;
	logic oe_n_nxt;

	assign request = |(sources & enables);

	always_comb begin
		// Registered so the pin never glitches on a partial mask update.
		pin_nxt = override_en ? override_val : request;
		oe_n_nxt = sleep;
		if (sleep) begin
			pin_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_r <= 1'b0;
			oe_n_r <= 1'b1;
		end else begin
			pin_r <= pin_nxt;
			oe_n_r <= oe_n_nxt;
		end
	end

	assign pin_o = pin_r;
	assign pin_oe_n = oe_n_r;
endmodule

// ===== design/ric_top.sv
// Interrupt controller for the radio: event latching, enables and two pins.
// Operation
// - Ten events latch into two source registers.
// - Two pins, each with own enable pair.
// - Status summary bit set if pin one requests, or pin two outside stream mode.
// - Writing one clears source bit; zero keeps.
// - Stream mode turns pin two into frame sync.
// - Both pins high impedance during sleep.
// - Outside sleep pins push-pull, active high.
// - Reset or wake enables only chip-accessible.
// - Power-up latches chip-accessible, idle, timer, power-on events.
// - High source bit layout, 7 to 5 reserved.
// - Low source bit layout, 7,6,0 reserved.
// - Packet sent event in packet mode.
// - Packet received only with valid check.
// - Delimiter sent event in packet mode.
// - Delimiter detected while in receive state.
// - Assessment complete event ends channel assessment.
// - Battery alert when enabled monitor reports low.
// - Idle event on rising idle flag.
// - Timer expiry event when timer reaches zero.
// - Chip-accessible on rising serial-ready after wake.
`timescale 1ns/100ps
module ric_top (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// Register access from the serial control port
	input wire ric_pkg::ric_access_t ACCESS,
	output logic [7:0] RDATA,
	// Event inputs from the radio units
	input wire ric_pkg::ric_events_t EVENTS,
	// Power state
	input wire logic SLEEP,
	input wire logic WAKE,
	// Streaming mode and its frame sync
	input wire logic SERIAL_STREAM_MODE,
	input wire logic FRAME_SYNC,
	// Status word summary
	output logic IRQ_SUMMARY,
	// Interrupt pins
	output logic FIRST_EVENT_PIN_O,
	output logic FIRST_EVENT_PIN_OE_N,
	output logic SECOND_EVENT_PIN_O,
	output logic SECOND_EVENT_PIN_OE_N
);
	logic [7:0] p1_en_lo_r, p1_en_lo_nxt;
	logic [7:0] p1_en_hi_r, p1_en_hi_nxt;
	logic [7:0] p2_en_lo_r, p2_en_lo_nxt;
	logic [7:0] p2_en_hi_r, p2_en_hi_nxt;
	logic [7:0] src_lo_r, src_lo_nxt;
	logic [7:0] src_hi_r, src_hi_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic powerup_pend_r, powerup_pend_nxt;
	logic woke_r, woke_nxt;
	logic [7:0] set_lo;
	logic [7:0] set_hi;
	logic idle_rise;
	logic ready_rise;
	logic req1;
	logic req2;

	function automatic logic hit(input ric_pkg::ric_access_t a, input logic [10:0] addr);
		hit = a.wr && (a.addr == addr);
	endfunction

	// The idle and serial-ready flags raise events on their rising edges only.
	ric_edge u_idle_edge (
		.clk(CLK),
		.rst_n(RST_N),
		.level(EVENTS.controller_idle_flag),
		.rise(idle_rise)
	);

	ric_edge u_ready_edge (
		.clk(CLK),
		.rst_n(RST_N),
		.level(EVENTS.serial_ready_flag),
		.rise(ready_rise)
	);

	// Qualified events: packet, delimiter, battery and chip-accessible events count only in the mode that gives them meaning.
	logic ev_pkt_sent;
	logic ev_pkt_received;
	logic ev_delim_sent;
	logic ev_delim_seen;
	logic ev_assess_done;
	logic ev_battery;
	logic ev_idle;
	logic ev_timer;
	logic ev_accessible;

	always_comb begin
		ev_pkt_sent = EVENTS.packet_mode & EVENTS.packet_sent;
		ev_pkt_received = EVENTS.packet_mode & EVENTS.packet_received & EVENTS.frame_check_ok;
		ev_delim_sent = EVENTS.packet_mode & EVENTS.delim_sent;
		ev_delim_seen = EVENTS.receive_state & EVENTS.delim_detected;
		ev_assess_done = EVENTS.assess_done;
		ev_battery = EVENTS.battery_monitor_on & EVENTS.battery_low;
		ev_idle = idle_rise;
		ev_timer = EVENTS.timer_zero;
		ev_accessible = ready_rise & woke_r;
	end

	// Event decode into source-register positions.
	always_comb begin
		set_lo = 8'h00;
		set_hi = 8'h00;
		set_hi[ric_pkg::HI_PACKET_SENT] = ev_pkt_sent;
		set_hi[ric_pkg::HI_PACKET_RECEIVED] = ev_pkt_received;
		set_hi[ric_pkg::HI_DELIM_SENT] = ev_delim_sent;
		set_hi[ric_pkg::HI_DELIM_DETECTED] = ev_delim_seen;
		set_hi[ric_pkg::HI_ASSESS_DONE] = ev_assess_done;
		set_lo[ric_pkg::LO_BATTERY_ALERT] = ev_battery;
		set_lo[ric_pkg::LO_CONTROLLER_IDLE] = ev_idle;
		set_lo[ric_pkg::LO_TIMER_EXPIRY] = ev_timer;
		set_lo[ric_pkg::LO_CHIP_ACCESSIBLE] = ev_accessible;
		if (powerup_pend_r) begin
			set_lo = set_lo | ric_pkg::SRC_LOW_POWERUP;
			set_lo[ric_pkg::LO_CHIP_ACCESSIBLE] = 1'b1;
		end
	end

	// Write strobes, one per register, decoded once and shared by the groups below.
	logic wr_p1_lo;
	logic wr_p1_hi;
	logic wr_p2_lo;
	logic wr_p2_hi;
	logic wr_src_lo;
	logic wr_src_hi;

	always_comb begin
		wr_p1_lo = hit(ACCESS, ric_pkg::PIN1_ENABLE_LOW_ADDR);
		wr_p1_hi = hit(ACCESS, ric_pkg::PIN1_ENABLE_HIGH_ADDR);
		wr_p2_lo = hit(ACCESS, ric_pkg::PIN2_ENABLE_LOW_ADDR);
		wr_p2_hi = hit(ACCESS, ric_pkg::PIN2_ENABLE_HIGH_ADDR);
		wr_src_lo = hit(ACCESS, ric_pkg::EVENT_SOURCE_LOW_ADDR);
		wr_src_hi = hit(ACCESS, ric_pkg::EVENT_SOURCE_HIGH_ADDR);
	end

	// A wake restores the power-up value and beats a write in the same cycle.
	function automatic logic [7:0] en_next(input logic [7:0] cur, input logic wr, input logic [7:0] data,
		input logic restore, input logic [7:0] init);
		en_next = cur;
		if (wr) begin
			en_next = data;
		end
		if (restore) begin
			en_next = init;
		end
	endfunction

	// Clear first and set afterwards, so an event that lands in the clearing cycle is kept.
	function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] sets, input logic clr,
		input logic [7:0] ones, input logic [7:0] impl);
		logic [7:0] kept;
		kept = clr ? (cur & ~ones) : cur;
		w1c = (kept | sets) & impl;
	endfunction

	// Pin one enable pair.
	always_comb begin
		p1_en_lo_nxt = en_next(p1_en_lo_r, wr_p1_lo, ACCESS.wdata, WAKE, ric_pkg::EN_LOW_RESET);
		p1_en_hi_nxt = en_next(p1_en_hi_r, wr_p1_hi, ACCESS.wdata, WAKE, ric_pkg::EN_HIGH_RESET);
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			p1_en_lo_r <= ric_pkg::EN_LOW_RESET;
			p1_en_hi_r <= ric_pkg::EN_HIGH_RESET;
		end else begin
			p1_en_lo_r <= p1_en_lo_nxt;
			p1_en_hi_r <= p1_en_hi_nxt;
		end
	end

	// Pin two enable pair.
	always_comb begin
		p2_en_lo_nxt = en_next(p2_en_lo_r, wr_p2_lo, ACCESS.wdata, WAKE, ric_pkg::EN_LOW_RESET);
		p2_en_hi_nxt = en_next(p2_en_hi_r, wr_p2_hi, ACCESS.wdata, WAKE, ric_pkg::EN_HIGH_RESET);
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			p2_en_lo_r <= ric_pkg::EN_LOW_RESET;
			p2_en_hi_r <= ric_pkg::EN_HIGH_RESET;
		end else begin
			p2_en_lo_r <= p2_en_lo_nxt;
			p2_en_hi_r <= p2_en_hi_nxt;
		end
	end

	// Sticky sources, cleared by writing ones; reserved bits never hold a value.
	always_comb begin
		src_lo_nxt = w1c(src_lo_r, set_lo, wr_src_lo, ACCESS.wdata, ric_pkg::LO_IMPL_MASK);
		src_hi_nxt = w1c(src_hi_r, set_hi, wr_src_hi, ACCESS.wdata, ric_pkg::HI_IMPL_MASK);
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			src_lo_r <= 8'h00;
			src_hi_r <= ric_pkg::SRC_HIGH_RESET;
		end else begin
			src_lo_r <= src_lo_nxt;
			src_hi_r <= src_hi_nxt;
		end
	end

	// Power-up pulse: high in the first cycle after reset only.
	always_comb begin
		powerup_pend_nxt = 1'b0;
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			powerup_pend_r <= 1'b1;
		end else begin
			powerup_pend_r <= powerup_pend_nxt;
		end
	end

	// Sleep seen: arms the chip-accessible event for the first serial-ready rise after sleep.
	always_comb begin
		woke_nxt = woke_r;
		if (SLEEP) begin
			woke_nxt = 1'b1;
		end else if (ready_rise) begin
			woke_nxt = 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			woke_r <= 1'b0;
		end else begin
			woke_r <= woke_nxt;
		end
	end

	// Read data holds until the next read, so the host may fetch it late.
	always_comb begin
		rdata_nxt = rdata_r;
		if (ACCESS.rd) begin
			unique case (ACCESS.addr)
				ric_pkg::PIN1_ENABLE_LOW_ADDR: rdata_nxt = p1_en_lo_r;
				ric_pkg::PIN1_ENABLE_HIGH_ADDR: rdata_nxt = p1_en_hi_r;
				ric_pkg::PIN2_ENABLE_LOW_ADDR: rdata_nxt = p2_en_lo_r;
				ric_pkg::PIN2_ENABLE_HIGH_ADDR: rdata_nxt = p2_en_hi_r;
				ric_pkg::EVENT_SOURCE_LOW_ADDR: rdata_nxt = src_lo_r;
				ric_pkg::EVENT_SOURCE_HIGH_ADDR: rdata_nxt = src_hi_r;
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// Sixteen-bit views with the high register in the upper byte.
	logic [15:0] src_all;
	logic [15:0] en1_all;
	logic [15:0] en2_all;

	assign src_all = {src_hi_r, src_lo_r};
	assign en1_all = {p1_en_hi_r, p1_en_lo_r};
	assign en2_all = {p2_en_hi_r, p2_en_lo_r};

	// Pin one is always the interrupt output.
	ric_pin u_pin1 (
		.clk(CLK),
		.rst_n(RST_N),
		.sources(src_all),
		.enables(en1_all),
		.override_en(1'b0),
		.override_val(1'b0),
		.sleep(SLEEP),
		.pin_o(FIRST_EVENT_PIN_O),
		.pin_oe_n(FIRST_EVENT_PIN_OE_N),
		.request(req1)
	);

	// Pin two is handed to frame sync in streaming mode.
	ric_pin u_pin2 (
		.clk(CLK),
		.rst_n(RST_N),
		.sources(src_all),
		.enables(en2_all),
		.override_en(SERIAL_STREAM_MODE),
		.override_val(FRAME_SYNC),
		.sleep(SLEEP),
		.pin_o(SECOND_EVENT_PIN_O),
		.pin_oe_n(SECOND_EVENT_PIN_OE_N),
		.request(req2)
	);

	logic req2_counted;

	// In streaming mode pin two carries no interrupt, so it does not feed the summary.
	assign req2_counted = req2 & ~SERIAL_STREAM_MODE;
	assign IRQ_SUMMARY = req1 | req2_counted;
	assign RDATA = rdata_r;
endmodule

// ===== dv/ric_sva.sv
// Checker for pin, summary and read-back behaviour of the interrupt controller.
`timescale 1ns/100ps
module ric_sva (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// Register port
	input wire ric_pkg::ric_access_t ACCESS,
	input wire logic [7:0] RDATA,
	// Modes and summary
	input wire logic SLEEP,
	input wire logic WAKE,
	input wire logic SERIAL_STREAM_MODE,
	input wire logic FRAME_SYNC,
	input wire logic IRQ_SUMMARY,
	// Pins
	input wire logic FIRST_EVENT_PIN_O,
	input wire logic FIRST_EVENT_PIN_OE_N,
	input wire logic SECOND_EVENT_PIN_O,
	input wire logic SECOND_EVENT_PIN_OE_N
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);
	property p_sleep;
		SLEEP |=> FIRST_EVENT_PIN_OE_N && SECOND_EVENT_PIN_OE_N && !FIRST_EVENT_PIN_O;
	endproperty
	a_sleep: assert property (p_sleep) else $error("pins driven in sleep");
	property p_drive;
		!SLEEP |=> !FIRST_EVENT_PIN_OE_N && !SECOND_EVENT_PIN_OE_N;
	endproperty
	a_drive: assert property (p_drive) else $error("pins released while awake");
	property p_sync;
		!SLEEP && SERIAL_STREAM_MODE |=> SECOND_EVENT_PIN_O == $past(FRAME_SYNC);
	endproperty
	a_sync: assert property (p_sync) else $error("frame sync not on pin two");
	property p_summary;
		!SLEEP && !SERIAL_STREAM_MODE |=> (FIRST_EVENT_PIN_O || SECOND_EVENT_PIN_O) == $past(IRQ_SUMMARY);
	endproperty
	a_summary: assert property (p_summary) else $error("summary differs from pins");
	property p_latch;
		IRQ_SUMMARY && !ACCESS.wr && !WAKE && !SERIAL_STREAM_MODE |=> IRQ_SUMMARY || SERIAL_STREAM_MODE;
	endproperty
	a_latch: assert property (p_latch) else $error("request dropped without clear");
	property p_lo_rsv;
		ACCESS.rd && ACCESS.addr == ric_pkg::EVENT_SOURCE_LOW_ADDR |=> RDATA[7:6] == 2'h0 && !RDATA[0];
	endproperty
	a_lo_rsv: assert property (p_lo_rsv) else $error("reserved source bit set");
	property p_unmap;
		ACCESS.rd && (ACCESS.addr < 11'h3c7 || ACCESS.addr > 11'h3cc) |=> RDATA == 8'h00;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_wake;
		WAKE ##1 (ACCESS.rd && !ACCESS.wr && ACCESS.addr == ric_pkg::PIN2_ENABLE_LOW_ADDR) |=> RDATA == 8'h02;
	endproperty
	a_wake: assert property (p_wake) else $error("enables not restored on wake");
endmodule
bind ric_top ric_sva ric_sva_i (.CLK(CLK), .RST_N(RST_N), .ACCESS(ACCESS), .RDATA(RDATA), .SLEEP(SLEEP),
	.WAKE(WAKE), .SERIAL_STREAM_MODE(SERIAL_STREAM_MODE), .FRAME_SYNC(FRAME_SYNC), .IRQ_SUMMARY(IRQ_SUMMARY),
	.FIRST_EVENT_PIN_O(FIRST_EVENT_PIN_O), .FIRST_EVENT_PIN_OE_N(FIRST_EVENT_PIN_OE_N),
	.SECOND_EVENT_PIN_O(SECOND_EVENT_PIN_O), .SECOND_EVENT_PIN_OE_N(SECOND_EVENT_PIN_OE_N));

// ===== dv/ric_host.sv
// Host model: register accesses on the control port and pin levels as seen.
`timescale 1ns/100ps
module ric_host (
	// Clock
	input wire logic clk,
	// Register port
	output ric_pkg::ric_access_t access,
	input wire logic [7:0] rdata,
	// Pins
	input wire logic [1:0] drv,
	input wire logic [1:0] drv_oe_n,
	output logic [1:0] level
);
	logic [1:0] last = 2'h0;
	initial access = '0;
	// A released pin floats, so the host sees the inverse of the last driven value.
	always @(posedge clk) last <= (drv_oe_n & last) | (~drv_oe_n & drv);
	assign level = (drv_oe_n & ~last) | (~drv_oe_n & drv);
	task automatic xfer(input bit w, input logic [10:0] a, input logic [7:0] d, output logic [7:0] q);
		access = '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge clk);
		#10 access = '0;
		@(posedge clk);
		#10 q = rdata;
	endtask
endmodule

// ===== dv/test_radio_interrupt_controller.sv
// Self-checking bench of the radio interrupt controller.
`timescale 1ns/100ps
module test_radio_interrupt_controller;
	logic clk = 0, rst_n = 0, sleep = 0, wake = 0, stream = 0, fsync = 0, summ, qual;
	ric_pkg::ric_events_t ev = '0;
	ric_pkg::ric_access_t acc;
	logic [7:0] rdata, q;
	logic [1:0] po, poe, lvl;
	logic [31:0] seed = 32'hadd9;
	logic [15:0] en, src, exp;
	int n_mismatch = 0, check_count = 0, k;
	int pos [8] = '{8 + ric_pkg::HI_ASSESS_DONE, 8 + ric_pkg::HI_DELIM_DETECTED, 8 + ric_pkg::HI_DELIM_SENT,
		8 + ric_pkg::HI_PACKET_RECEIVED, 8 + ric_pkg::HI_PACKET_SENT, ric_pkg::LO_BATTERY_ALERT,
		ric_pkg::LO_CONTROLLER_IDLE, ric_pkg::LO_TIMER_EXPIRY};
	ric_top ric_top_i (.CLK(clk), .RST_N(rst_n), .ACCESS(acc), .RDATA(rdata), .EVENTS(ev), .SLEEP(sleep),
		.WAKE(wake), .SERIAL_STREAM_MODE(stream), .FRAME_SYNC(fsync), .IRQ_SUMMARY(summ),
		.FIRST_EVENT_PIN_O(po[0]), .FIRST_EVENT_PIN_OE_N(poe[0]), .SECOND_EVENT_PIN_O(po[1]),
		.SECOND_EVENT_PIN_OE_N(poe[1]));
	ric_host ric_host_i (.clk(clk), .access(acc), .rdata(rdata), .drv(po), .drv_oe_n(poe), .level(lvl));
	initial forever #50 clk = ~clk;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	// Qualified events only; events 0, 6 and 7 have no qualifier.
	function automatic logic [15:0] expect_src(input int k, input bit qual);
		return (qual || k == 0 || k > 5) ? 16'h0001 << pos[k] : 16'h0000;
	endfunction
	task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", name, e, g);
		end
	endtask
	task automatic wr(input logic [10:0] a, input logic [7:0] d);
		ric_host_i.xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [10:0] a);
		ric_host_i.xfer(1'b0, a, 8'h00, q);
	endtask
	task automatic rds();
		rd(ric_pkg::EVENT_SOURCE_HIGH_ADDR);
		src[15:8] = q;
		rd(ric_pkg::EVENT_SOURCE_LOW_ADDR);
		src[7:0] = q;
	endtask
	task automatic wen(input logic [10:0] base, input logic [15:0] e);
		wr(base, e[7:0] & ric_pkg::LO_IMPL_MASK);
		wr(base + 11'h1, e[15:8] & ric_pkg::HI_IMPL_MASK);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		#1000000;
		n_mismatch++;
		tally_and_finish();
	end
	initial begin
		repeat (10) @(posedge clk);
		#10 rst_n = 1;
		repeat (3) @(posedge clk);
		#10 chk("pins after reset", 16'h0003, 16'(lvl));
		rds();
		chk("power-up sources", 16'h001e, src);
		for (int a = 'h3c7; a < 'h3cb; a++) begin
			rd(11'(a));
			chk("enable reset", (a % 2) ? 16'h0002 : 16'h0000, 16'(q));
		end
		wr(ric_pkg::EVENT_SOURCE_LOW_ADDR, 8'hff);
		wr(ric_pkg::EVENT_SOURCE_HIGH_ADDR, 8'hff);
		for (int i = 0; i < 48; i++) begin
			seed = xs(seed);
			en = seed[15:0] & {ric_pkg::HI_IMPL_MASK, ric_pkg::LO_IMPL_MASK};
			k = (i < 16) ? i / 2 : int'(seed[18:16]);
			qual = (i < 16) ? i[0] : seed[19];
			wen(ric_pkg::PIN1_ENABLE_LOW_ADDR, en);
			wen(ric_pkg::PIN2_ENABLE_LOW_ADDR, ~en);
			case (k)
				0: ev.assess_done = 1'b1;
				1: {ev.delim_detected, ev.receive_state} = {1'b1, qual};
				2: {ev.delim_sent, ev.packet_mode} = {1'b1, qual};
				3: {ev.packet_received, ev.packet_mode, ev.frame_check_ok} = {2'h3, qual};
				4: {ev.packet_sent, ev.packet_mode} = {1'b1, qual};
				5: {ev.battery_low, ev.battery_monitor_on} = {1'b1, qual};
				6: ev.controller_idle_flag = 1'b1;
				default: ev.timer_zero = 1'b1;
			endcase
			@(posedge clk);
			#10 ev = '0;
			exp = expect_src(k, qual);
			rds();
			chk("source high", exp >> 8, src >> 8);
			chk("source low", exp & 16'h00ff, src & 16'h00ff);
			chk("pins", {14'h0, |(exp & ~en), |(exp & en)}, 16'(lvl));
			chk("summary", 16'(|exp), 16'(summ));
			wr(ric_pkg::EVENT_SOURCE_LOW_ADDR, 8'h00);
			wr(ric_pkg::EVENT_SOURCE_HIGH_ADDR, 8'h00);
			rds();
			chk("zero write keeps", exp, src);
			wr(ric_pkg::EVENT_SOURCE_LOW_ADDR, exp[7:0]);
			wr(ric_pkg::EVENT_SOURCE_HIGH_ADDR, exp[15:8]);
			rds();
			chk("one write clears", 16'h0000, src);
		end
		stream = 1;
		repeat (6) begin
			seed = xs(seed);
			fsync = seed[0];
			@(posedge clk);
			#10 chk("frame sync", 16'(fsync), 16'(lvl[1]));
		end
		stream = 0;
		rd(11'h3c6);
		chk("unmapped read", 16'h0000, 16'(q));
		rd(11'h3cd);
		chk("unmapped read", 16'h0000, 16'(q));
		sleep = 1;
		@(posedge clk);
		#10 chk("released in sleep", 16'h0003, 16'(poe));
		sleep = 0;
		wake = 1;
		@(posedge clk);
		#10 wake = 0;
		rd(ric_pkg::PIN2_ENABLE_LOW_ADDR);
		chk("enables after wake", 16'h0002, 16'(q));
		ev.serial_ready_flag = 1;
		rds();
		chk("chip accessible", 16'h0002, src);
		chk("power-up on pins", 16'h0003, 16'(lvl));
		tally_and_finish();
	end
endmodule
